//--- iface_card_model.sv
/*
 * Behavioural network interface card that sits behind the reset
 * supervisor. It boots a fixed time after its reset falls and can be
 * made to lock up or to report a lost link on command.
 * Assumes reset and commands are synchronous to hclk.
 */
`default_nettype none
module iface_card_model #(
   parameter int BOOT_CYC = 30  // Boot time after reset falls
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic iface_reset,
   input  wire logic hang_cmd,
   input  wire logic loss_cmd,
   input  wire logic fd_cmd,
   input  wire logic lg_cmd,
   input  wire logic rp_cmd,
   output logic      iface_full_duplex,
   output logic      iface_link_good,
   output logic      iface_resource_problem,
   output logic      iface_hang,
   output logic      iface_up,
   output logic      iface_loss
);
   timeunit 1ns;
   timeprecision 1ps;
   int   boot_q;  // Cycles left of boot
   logic hung_q;  // Locked up until the next reset
   // Every reset restarts the boot, even one still in progress
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_q <= BOOT_CYC;
      end else if (iface_reset) begin
         boot_q <= BOOT_CYC;
      end else if (boot_q != 0) begin
         boot_q <= boot_q - 1;
      end
   end
   // A lockup clears only by reset, so the bench must issue one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hung_q <= 1'b0;
      end else if (iface_reset) begin
         hung_q <= 1'b0;
      end else if (hang_cmd) begin
         hung_q <= 1'b1;
      end
   end
   assign iface_up = (boot_q == 0) && !hung_q;
   assign iface_hang = hung_q;
   // Link status means nothing while the card is down
   assign iface_full_duplex = iface_up & fd_cmd;
   assign iface_link_good = iface_up & lg_cmd;
   assign iface_resource_problem = iface_up & rp_cmd;
   assign iface_loss = loss_cmd;
endmodule : iface_card_model
`default_nettype wire

//--- iface_reset_supervisor.sv
/*
 * Network interface reset supervisor: takes the interface reset service
 * call over AHB-Lite, drives the interface reset, tracks start-up and
 * health, and presents the status bit bank and an interrupt.
 * Assumes a single slave on the bus (hready is its own hreadyout) and
 * interface status inputs synchronous to hclk.
 */
// Functional notes
// - Reset call 24 takes one rack/slot word
// - Act only when rack/slot word is zero
// - Every accepted call resets, even during start-up
// - Simultaneous requests merge into one reset
// - Interface healthy only after start-up period
// - Healthy bit drops on reset or loss
// - Hang bit set on lockup; advises reset
// - Status bank layout, reserved bits read zero
`include "iface_supervisor_consts.svh"
`default_nettype none
module iface_reset_supervisor #(
   parameter int HOLD_CYC    = `RESET_HOLD_CYC,   // Interface reset width
   parameter int STARTUP_CYC = `STARTUP_CYC,      // Start-up wait
   parameter int RECOVER_CYC = `RECOVER_CYC       // Recovery watchdog
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        iface_full_duplex,
   input  wire logic        iface_link_good,
   input  wire logic        iface_resource_problem,
   input  wire logic        iface_hang,
   input  wire logic        iface_up,
   input  wire logic        iface_loss,
   input  wire logic        button_reset_req,
   output logic             iface_reset,
   output logic             call_success,
   output logic             irq
);
   localparam int HOLD_LIM = HOLD_CYC + 1;   // Bound for the pulse check

   // Bus capture
   logic        wr_q;          // Write data phase pending
   logic [7:0]  waddr_q;       // Write offset
   logic [31:0] rdata_q;       // Read data register
   // Software registers
   logic [`PARAM_W-1:0] param_q;     // Rack/slot parameter word
   logic [1:0]          result_q;    // Last call: done, success
   logic [`EV_W-1:0]    ev_stat_q;   // Sticky events
   logic [`EV_W-1:0]    ev_mask_q;   // Event enables
   // Sequence
   iface_supervisor_pkg::sup_state_t state_q;
   iface_supervisor_pkg::sup_state_t state_d;
   logic        reset_q;       // Interface reset output flop
   logic [15:0] hold_q;        // Reset cycles left
   logic        success_q;     // Success output flop
   logic        healthy_q;     // Interface healthy
   logic        healthy_d;
   logic        button_q;      // Button level last cycle
   logic        hang_q;        // Hang level last cycle
   // Request decode
   logic        bus_take;      // Address phase accepted
   logic        call_wr;       // Write to the call register
   logic        sw_ok;         // Valid reset call
   logic        sw_bad;        // Refused reset call
   logic        btn_req;       // Button request edge
   logic        any_req;       // Merged request
   logic        start_go;      // Start-up period begins
   logic        first_q;       // First cycle after reset release
   logic        start_exp;     // Start-up period over
   logic        rec_exp;       // Recovery watchdog fired
   logic [`STAT_W-1:0] stat;   // Status bank
   logic [`EV_W-1:0]   ev_set; // Events this cycle
   logic [`EV_W-1:0]   ev_clr; // Write-one-to-clear

   assign bus_take  = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;    // Zero wait states
   assign hresp     = 1'b0;    // Always OKAY
   assign hrdata    = rdata_q;

   // Write address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         waddr_q <= 8'h00;
      end else if (hready) begin
         wr_q    <= bus_take && hwrite;
         waddr_q <= haddr[7:0];
      end
   end

   // Read data latched in the address phase, so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_take && !hwrite) begin
         case (haddr[7:0])
            `OFS_PARAM:    rdata_q <= {16'h0000, param_q};
            `OFS_RESULT:   rdata_q <= {30'h0000_0000, result_q};
            `OFS_STAT0:    rdata_q <= stat[31:0];
            `OFS_STAT1:    rdata_q <= stat[63:32];
            `OFS_STAT2:    rdata_q <= {16'h0000, stat[79:64]};
            `OFS_IRQ_STAT: rdata_q <= {27'h000_0000, ev_stat_q};
            `OFS_IRQ_MASK: rdata_q <= {27'h000_0000, ev_mask_q};
            default:       rdata_q <= 32'h0000_0000;   // Call reg and holes
         endcase
      end
   end

   // Parameter word; only the low half word is the parameter block
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         param_q <= `RST_PARAM;
      end else if (wr_q && waddr_q == `OFS_PARAM) begin
         param_q <= hwdata[`PARAM_W-1:0];
      end
   end

   // Mask register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_mask_q <= `RST_MASK;
      end else if (wr_q && waddr_q == `OFS_IRQ_MASK) begin
         ev_mask_q <= hwdata[`EV_W-1:0];
      end
   end

   // Call decode; other service numbers are ignored
   assign call_wr = wr_q && waddr_q == `OFS_CALL && hwdata[7:0] == `SVC_IFACE_RESET;
   assign sw_ok   = call_wr && param_q == `RACK_SLOT_LOCAL;
   assign sw_bad  = call_wr && param_q != `RACK_SLOT_LOCAL;

   // Button edge only, so a held button cannot keep resetting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         button_q <= 1'b0;
      end else begin
         button_q <= button_reset_req;
      end
   end
   assign btn_req = button_reset_req && !button_q;

   // All sources in one cycle become one request
   assign any_req = sw_ok || btn_req;

   // Last call result, readable by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= 2'b00;
      end else if (call_wr) begin
         result_q <= {1'b1, sw_ok};
      end
   end

   // Sequence: reset pulse, start-up wait, run
   always_comb begin
      state_d = state_q;
      case (state_q)
         iface_supervisor_pkg::ST_RESET: begin
            if (hold_q == 16'h0001 && !any_req) begin
               state_d = iface_supervisor_pkg::ST_STARTUP;
            end
         end
         iface_supervisor_pkg::ST_STARTUP: begin
            if (start_exp) begin
               state_d = iface_supervisor_pkg::ST_RUN;
            end
         end
         iface_supervisor_pkg::ST_RUN: begin
            state_d = iface_supervisor_pkg::ST_RUN;
         end
         default: begin
            state_d = iface_supervisor_pkg::ST_STARTUP;
         end
      endcase
      // A request restarts everything, start-up or not
      if (any_req) begin
         state_d = iface_supervisor_pkg::ST_RESET;
      end
   end

   // State register; out of reset the interface is starting up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= iface_supervisor_pkg::ST_STARTUP;
      end else begin
         state_q <= state_d;
      end
   end

   // Reset width counter; a request reloads it, so overlaps stay one pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= 16'h0000;
      end else if (any_req) begin
         hold_q <= 16'(HOLD_CYC);
      end else if (hold_q != 16'h0000) begin
         hold_q <= hold_q - 16'h0001;
      end
   end

   // Registered reset and success outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_q   <= 1'b0;
         success_q <= 1'b0;
      end else begin
         reset_q   <= (state_d == iface_supervisor_pkg::ST_RESET);
         success_q <= sw_ok;
      end
   end
   assign iface_reset  = reset_q;
   assign call_success = success_q;

   // Start-up period starts as the reset pulse ends
   assign start_go = (state_q == iface_supervisor_pkg::ST_RESET)
                     && (state_d == iface_supervisor_pkg::ST_STARTUP);

   // Interface boots with us, so the start-up wait also runs after release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   interval_timer #(
      .W     (`TIMER_W),
      .COUNT (30'(STARTUP_CYC))
   ) u_startup (
      .clk     (hclk),
      .rst_n   (hresetn),
      .start   (start_go || first_q),
      .cancel  (any_req),
      .running (),
      .expired (start_exp)
   );

   // Healthy only in run with the interface up and no loss
   always_comb begin
      healthy_d = healthy_q;
      if (any_req || iface_loss) begin
         healthy_d = 1'b0;
      end else if (state_q == iface_supervisor_pkg::ST_RUN && iface_up) begin
         healthy_d = 1'b1;
      end else if (!iface_up) begin
         healthy_d = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         healthy_q <= 1'b0;
      end else begin
         healthy_q <= healthy_d;
      end
   end

   // Watchdog from the last fall of healthy; fires if it stays low too long
   interval_timer #(
      .W     (`TIMER_W),
      .COUNT (30'(RECOVER_CYC))
   ) u_recover (
      .clk     (hclk),
      .rst_n   (hresetn),
      .start   (healthy_q && !healthy_d),
      .cancel  (healthy_d),
      .running (),
      .expired (rec_exp)
   );

   // Hang edge history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hang_q <= 1'b0;
      end else begin
         hang_q <= iface_hang;
      end
   end

   // Status bank; every other bit is reserved and reads zero
   always_comb begin
      stat                    = '0;
      stat[`SIDX_FULL_DUPLEX] = iface_full_duplex;
      stat[`SIDX_LINK_GOOD]   = iface_link_good;
      stat[`SIDX_RESOURCE]    = iface_resource_problem;
      stat[`SIDX_HANG]        = iface_hang;
      stat[`SIDX_HEALTHY]     = healthy_q;
   end

   // Events feeding the interrupt
   always_comb begin
      ev_set                   = '0;
      ev_set[`EV_ISSUED]       = any_req;
      ev_set[`EV_REFUSED]      = sw_bad;
      ev_set[`EV_HEALTH_LOST]  = healthy_q && !healthy_d;
      ev_set[`EV_HANG]         = iface_hang && !hang_q;
      ev_set[`EV_RECOVER_LATE] = rec_exp;
      ev_clr                   = '0;
      if (wr_q && waddr_q == `OFS_IRQ_STAT) begin
         ev_clr = hwdata[`EV_W-1:0];
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_stat_q <= '0;
      end else begin
         ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
      end
   end

   // Level interrupt from unmasked sticky bits
   assign irq = |(ev_stat_q & ev_mask_q);

   // Checks
   refused_call_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (sw_bad && !btn_req && !reset_q) |=> !call_success && !iface_reset)
      else $error("refused call still reset the interface");
   accepted_call_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sw_ok |=> call_success && iface_reset)
      else $error("valid call gave no reset and success");
   success_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      call_success |-> iface_reset && $past(param_q) == `RACK_SLOT_LOCAL)
      else $error("success without an issued reset");
   reset_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(iface_reset) |-> iface_reset[*2] ##[1:HOLD_LIM] !iface_reset)
      else $error("interface reset width wrong");
   startup_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == iface_supervisor_pkg::ST_STARTUP && any_req)
      |=> state_q == iface_supervisor_pkg::ST_RESET && iface_reset)
      else $error("request during start-up not honoured");
   healthy_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (any_req || iface_loss) |=> !stat[`SIDX_HEALTHY])
      else $error("healthy bit kept after reset or loss");
   healthy_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(healthy_q) |-> $past(state_q) == iface_supervisor_pkg::ST_RUN)
      else $error("healthy before start-up finished");
   hang_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(iface_hang) |=> ev_stat_q[`EV_HANG] && stat[`SIDX_HANG] == iface_hang)
      else $error("lockup not flagged");
   reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      stat[1:0] == 2'b00 && stat[11:3] == '0 && stat[79:16] == '0)
      else $error("reserved status bit set");
   merged_req_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (sw_ok && btn_req) |=> hold_q == 16'(HOLD_CYC) && iface_reset)
      else $error("merged requests not one reset");
endmodule : iface_reset_supervisor
`default_nettype wire

//--- iface_supervisor_consts.svh
/*
 * Register offsets, status bit positions, event bits and timing figures
 * of the network interface reset supervisor.
 * Assumes a 100 MHz system clock and an AHB-Lite word-wide register bus.
 */
`ifndef IFACE_SUPERVISOR_CONSTS_SVH
`define IFACE_SUPERVISOR_CONSTS_SVH

// Register byte offsets
`define OFS_CALL        8'h00
`define OFS_PARAM       8'h04
`define OFS_RESULT      8'h08
`define OFS_STAT0       8'h10
`define OFS_STAT1       8'h14
`define OFS_STAT2       8'h18
`define OFS_IRQ_STAT    8'h20
`define OFS_IRQ_MASK    8'h24

// Service call number and the only target word accepted
`define SVC_IFACE_RESET 8'h18
`define RACK_SLOT_LOCAL 16'h0000
`define PARAM_W         16

// Status bank: status bit n sits at vector index n-1
`define STAT_W          80
`define SIDX_FULL_DUPLEX 2
`define SIDX_LINK_GOOD  12
`define SIDX_RESOURCE   13
`define SIDX_HANG       14
`define SIDX_HEALTHY    15

// Event bits of the interrupt status and mask registers
`define EV_ISSUED       0
`define EV_REFUSED      1
`define EV_HEALTH_LOST  2
`define EV_HANG         3
`define EV_RECOVER_LATE 4
`define EV_W            5

// Reset values
`define RST_PARAM       16'h0000
`define RST_MASK        5'h00

// Timing
`define CLK_MHZ         100
`define STARTUP_MS      5300
`define RECOVER_MS      7000
`define RESET_HOLD_NS   1000
`define STARTUP_CYC     (`STARTUP_MS * `CLK_MHZ * 1000)
`define RECOVER_CYC     (`RECOVER_MS * `CLK_MHZ * 1000)
`define RESET_HOLD_CYC  ((`RESET_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define TIMER_W         30

`endif

//--- iface_supervisor_pkg.sv
/*
 * Types of the network interface reset supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package iface_supervisor_pkg;
   // Supervisor sequence
   typedef enum logic [1:0] {ST_RESET, ST_STARTUP, ST_RUN} sup_state_t;
endpackage : iface_supervisor_pkg
`default_nettype wire

//--- interval_timer.sv
/*
 * Restartable down-counting interval timer with a one-cycle expiry pulse.
 * Assumes start and cancel are synchronous to clk.
 */
`default_nettype none
module interval_timer #(
   parameter int          W     = 30,
   parameter logic [29:0] COUNT = 30'h3FFFFFFF
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,    // Load and run; wins over cancel
   input  wire logic cancel,   // Stop without expiry
   output logic      running,  // Counting
   output logic      expired   // One-cycle pulse at the end
);
   logic [W-1:0] cnt_q;        // Cycles left
   logic         exp_q;        // Expiry flop

   // Count down while loaded
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= COUNT[W-1:0];
      end else if (cancel) begin
         cnt_q <= '0;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   // Pulse when the last cycle passes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exp_q <= 1'b0;
      end else begin
         exp_q <= (cnt_q == W'(1)) && !start && !cancel;
      end
   end

   assign running = (cnt_q != '0);
   assign expired = exp_q;
endmodule : interval_timer
`default_nettype wire

//--- tb_iface_reset_supervisor.sv
/*
 * Self-checking bench of the reset supervisor: AHB-Lite master tasks,
 * a card model, random targets and status, and reset pulse monitors.
 * Assumes the shortened timing parameters set below.
 */
`include "iface_supervisor_consts.svh"
`default_nettype none
module tb_iface_reset_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_C  = 4;     // Shortened reset width
   localparam int START_C = 50;    // Shortened start-up wait
   localparam int RECOV_C = 80;    // Shortened recovery watchdog
   localparam int LIMIT_C = 5000;  // Whole run fits well inside
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        button_reset_req, iface_reset, call_success, irq;
   logic        hang_cmd, loss_cmd, fd_cmd, lg_cmd, rp_cmd, rst_prev;
   logic        iface_full_duplex, iface_link_good, iface_resource_problem;
   logic        iface_hang, iface_up, iface_loss;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] p;
   logic [31:0] haddr, hwdata, hrdata, rnd, hi_len;
   int          n_errors, n_tests, cyc, rst_rises, succ_n, t0, w, s, k;
   assign hready = hreadyout;  // Single slave
   iface_reset_supervisor #(.HOLD_CYC(HOLD_C), .STARTUP_CYC(START_C),
      .RECOVER_CYC(RECOV_C)) iface_reset_supervisor_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .iface_full_duplex(iface_full_duplex), .iface_link_good(iface_link_good),
      .iface_resource_problem(iface_resource_problem),
      .iface_hang(iface_hang), .iface_up(iface_up), .iface_loss(iface_loss),
      .button_reset_req(button_reset_req), .iface_reset(iface_reset),
      .call_success(call_success), .irq(irq));
   iface_card_model iface_card_model_i (
      .hclk(hclk), .hresetn(hresetn), .iface_reset(iface_reset),
      .hang_cmd(hang_cmd), .loss_cmd(loss_cmd), .fd_cmd(fd_cmd),
      .lg_cmd(lg_cmd), .rp_cmd(rp_cmd), .iface_full_duplex(iface_full_duplex),
      .iface_link_good(iface_link_good),
      .iface_resource_problem(iface_resource_problem),
      .iface_hang(iface_hang), .iface_up(iface_up), .iface_loss(iface_loss));
   // Free-running system clock
   always #5 hclk = ~hclk;
   // Random source, fixed start
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr
   // Status word 1..32 as the card presents it
   function automatic logic [31:0] exp_stat(input logic up, input logic hg,
                                            input logic ok);
      logic [31:0] v;
      v = 32'h00000000;
      v[`SIDX_FULL_DUPLEX] = up & fd_cmd;
      v[`SIDX_LINK_GOOD] = up & lg_cmd;
      v[`SIDX_RESOURCE] = up & rp_cmd;
      v[`SIDX_HANG] = hg;
      v[`SIDX_HEALTHY] = ok;
      return v;
   endfunction : exp_stat
   task automatic finish_test;
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // One single transfer; the button may rise with the data phase
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                      input logic btn, output logic [31:0] rd);
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsel <= 1'b1;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h00000000;
      if (btn) button_reset_req <= 1'b1;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(a, 1'b1, d, 1'b0, rd);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] rd;
      bus(a, 1'b0, 32'h00000000, 1'b0, rd);
      chk(rd, e);
      chk({31'h0, hresp}, 32'h0);
   endtask : rd_chk
   // Target word first, then the call itself, two writes per request
   task automatic do_call(input logic [31:0] prm, input logic btn);
      logic [31:0] rd;
      wr(`OFS_PARAM, prm);
      bus(`OFS_CALL, 1'b1, {24'h000000, `SVC_IFACE_RESET}, btn, rd);
   endtask : do_call
   // Check chosen event bits, then clear them by writing ones
   task automatic ev_chk(input logic [4:0] m, input logic [4:0] e);
      logic [31:0] rd;
      bus(`OFS_IRQ_STAT, 1'b0, 32'h00000000, 1'b0, rd);
      chk(rd & {27'h0, m}, {27'h0, e});
      wr(`OFS_IRQ_STAT, {27'h0, m});
   endtask : ev_chk
   task automatic irq_chk(input logic e);
      #1;
      chk({31'h0, irq}, {31'h0, e});
   endtask : irq_chk
   // Poll until healthy; too early a rise shows in the elapsed count
   // Later requests wait for this recovery, as software should
   task automatic wait_up(input int from, input int min_c);
      logic [31:0] rd;
      int          i;
      rd = 32'h00000000;
      for (i = 0; i < 200 && rd[`SIDX_HEALTHY] !== 1'b1; i++)
         bus(`OFS_STAT0, 1'b0, 32'h00000000, 1'b0, rd);
      chk({31'h0, (cyc - from) >= min_c}, 32'h1);
      chk(rd, exp_stat(1'b1, 1'b0, 1'b1));
   endtask : wait_up
   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc >= LIMIT_C) begin
         n_errors++;
         finish_test();
      end
   end
   // Reset pulses: count rises, check width and the success pulse
   always @(posedge hclk) begin
      if (iface_reset === 1'b1) begin
         if (rst_prev !== 1'b1) rst_rises++;
         hi_len = (rst_prev === 1'b1) ? hi_len + 1 : 32'h1;
      end else if (rst_prev === 1'b1) chk(hi_len, HOLD_C);
      if (call_success === 1'b1) succ_n++;
      if (call_success === 1'b1) chk({30'h0, iface_reset, rst_prev}, 32'h2);
      rst_prev = iface_reset;
   end
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      button_reset_req = 1'b0;
      {hang_cmd, loss_cmd, fd_cmd, lg_cmd, rp_cmd} = 5'h06;
      rnd = 32'h0000EA5B;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t0 = cyc;
      // Reset values, reserved and unmapped words
      rd_chk(`OFS_PARAM, 32'h0);
      rd_chk(`OFS_IRQ_MASK, 32'h0);
      rd_chk(`OFS_STAT1, 32'h0);
      rd_chk(`OFS_STAT2, 32'h0);
      rd_chk(8'h3C, 32'h0);
      wait_up(t0, START_C);
      // Non-zero targets: corners, then random; status also random
      for (k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         p = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0001 : rnd[15:0] | 16'h0100;
         {fd_cmd, lg_cmd, rp_cmd} <= rnd[18:16];
         w = rst_rises;
         do_call({rnd[31:16], p}, 1'b0);
         rd_chk(`OFS_PARAM, {16'h0000, p});
         repeat (HOLD_C) @(posedge hclk);
         chk(rst_rises, w);
         rd_chk(`OFS_RESULT, 32'h2);
         ev_chk(5'h02, 5'h02);
      end
      // Refusal event through the interrupt: masked, unmasked, cleared
      do_call(32'h00000001, 1'b0);
      irq_chk(1'b0);
      wr(`OFS_IRQ_MASK, 32'h02);
      irq_chk(1'b1);
      wr(`OFS_IRQ_STAT, 32'h02);
      irq_chk(1'b0);
      // Another call number with a good target does nothing
      wr(`OFS_PARAM, 32'h0);
      wr(`OFS_CALL, 32'h00000017);
      repeat (HOLD_C) @(posedge hclk);
      chk(rst_rises, w);
      // Accepted call: one reset, one success, health drops
      s = succ_n;
      do_call(32'h0, 1'b0);
      rd_chk(`OFS_RESULT, 32'h3);
      chk(rst_rises, w + 1);
      chk(succ_n, s + 1);
      rd_chk(`OFS_STAT0, exp_stat(1'b0, 1'b0, 1'b0));
      ev_chk(5'h05, 5'h05);
      // Second call while still starting up resets again
      do_call(32'h0, 1'b0);
      t0 = cyc;
      repeat (3) @(posedge hclk);
      chk(rst_rises, w + 2);
      wait_up(t0, HOLD_C + START_C);
      wr(`OFS_IRQ_STAT, 32'h1F);
      // Button and call together give one reset
      w = rst_rises;
      s = succ_n;
      do_call(32'h0, 1'b1);
      t0 = cyc;
      button_reset_req <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(rst_rises, w + 1);
      chk(succ_n, s + 1);
      wait_up(t0, HOLD_C + START_C);
      ev_chk(5'h1F, 5'h05);
      // Button alone: reset without a success pulse
      button_reset_req <= 1'b1;
      t0 = cyc;
      repeat (3) @(posedge hclk);
      button_reset_req <= 1'b0;
      chk(rst_rises, w + 2);
      chk(succ_n, s + 1);
      wait_up(t0, HOLD_C + START_C);
      // Lockup: hang bit, interrupt, then a reset clears it
      hang_cmd <= 1'b1;
      repeat (2) @(posedge hclk);
      hang_cmd <= 1'b0;
      rd_chk(`OFS_STAT0, exp_stat(1'b0, 1'b1, 1'b0));
      wr(`OFS_IRQ_MASK, 32'h08);
      irq_chk(1'b1);
      ev_chk(5'h0C, 5'h0C);
      irq_chk(1'b0);
      do_call(32'h0, 1'b0);
      t0 = cyc;
      wait_up(t0, HOLD_C + START_C);
      // Loss: health drops, late-recovery event, then reset
      loss_cmd <= 1'b1;
      repeat (3) @(posedge hclk);
      rd_chk(`OFS_STAT0, exp_stat(1'b1, 1'b0, 1'b0));
      repeat (RECOV_C) @(posedge hclk);
      ev_chk(5'h14, 5'h14);
      loss_cmd <= 1'b0;
      do_call(32'h0, 1'b0);
      t0 = cyc;
      wait_up(t0, HOLD_C + START_C);
      finish_test();
   end
endmodule : tb_iface_reset_supervisor
`default_nettype wire
